// ==== ocp_consts.svh ====
`ifndef OCP_CONSTS_SVH
`define OCP_CONSTS_SVH

// register byte offsets
`define OCP_OFF_CTRL 8'h00
`define OCP_OFF_PRI 8'h04
`define OCP_OFF_SEC 8'h08
`define OCP_OFF_STAT 8'h0C

// compare_control fields
`define OCP_CTRL_MODE_MSB 2
`define OCP_CTRL_MODE_LSB 0
`define OCP_CTRL_TSEL_BIT 3
`define OCP_CTRL_FAULT_BIT 4

// status fields
`define OCP_STAT_FLAG_BIT 0
`define OCP_STAT_IEN_BIT 1
`define OCP_STAT_PIN_BIT 2

// compare_mode_select encodings
`define OCP_MODE_OFF 3'h0
`define OCP_MODE_SINGLE 3'h4
`define OCP_MODE_CONT 3'h5
`define OCP_MODE_PWM 3'h6
`define OCP_MODE_PWM_FAULT 3'h7

// reset values
`define OCP_CMP_RESET 16'h0000
`define OCP_MODE_RESET 3'h0
`define OCP_WORD_RESET 32'h0000_0000
`define OCP_COUNT_ZERO 16'h0000

`endif

// ==== ocp_pkg.sv ====
package ocp_pkg;

    typedef enum logic [1:0] {
        ocp_st_idle,
        ocp_st_rise,
        ocp_st_fall,
        ocp_st_done
    } ocp_pulse_state_t;

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] period;
        logic tick;
    } ocp_timer_t;

    typedef struct packed {
        logic pin;
        ocp_pulse_state_t pstate;
        logic [2:0] mode;
        logic tsel;
        logic fault;
        logic [15:0] primary;
        logic [15:0] secondary;
        logic irq_flag;
        logic irq_en;
        logic [31:0] rdata;
        logic slverr;
    } ocp_state_t;

endpackage

// ==== ocp_output_compare.sv ====
// Function
// - single-pulse mode write forces pin low, arms
// - primary match drives pin high in pulse modes
// - single-pulse secondary match drops pin, no more pulses
// - secondary match sets flag in pulse modes; request needs enable
// - rewriting single-pulse mode re-arms without timer reset
// - continuous mode: low first, pulse every cycle
// - count equal period wraps to zero, repeats
// - continuous mode flags the secondary match that ends each pulse
// - pwm period comes from selected timer period
// - secondary copies into primary on period match
// - primary read-only while in pwm modes
// - primary at enable is first duty only if no period match precedes the first zero
// - two pwm modes; fault mode uses interrupt
// - period value n gives n plus one counts
// - duty zero low, above period high
// - fault sets status flag, cleared by hardware at period start or by any control write
// - source select high picks third timer
`include "ocp_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module ocp_output_compare (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ocp_pkg::ocp_timer_t timer2_bus,
    input wire ocp_pkg::ocp_timer_t timer3_bus,
    input wire logic fault_n,
    output logic compare_output_pin,
    output logic compare_irq_flag,
    output logic compare_irq_request,
    output logic fault_status_flag
);

    ocp_pkg::ocp_state_t state_reg;
    ocp_pkg::ocp_state_t state_next;
    ocp_pkg::ocp_timer_t tb;
    logic zero_hit;
    logic period_hit;
    logic pri_hit;
    logic sec_hit;
    logic apb_setup;
    logic apb_write;
    logic [31:0] rd_word;
    logic rd_err;

    function automatic logic addr_is(
        input logic [7:0] a,
        input logic [7:0] off
    );
        addr_is = (a == off);
    endfunction

    function automatic logic mode_is_pwm(input logic [2:0] m);
        mode_is_pwm = (m == `OCP_MODE_PWM) || (m == `OCP_MODE_PWM_FAULT);
    endfunction

    function automatic logic mode_is_pulse(input logic [2:0] m);
        mode_is_pulse = (m == `OCP_MODE_SINGLE) || (m == `OCP_MODE_CONT);
    endfunction

    // time base select and compare strobes
    always_comb begin
        if (state_reg.tsel) begin
            tb = timer3_bus;
        end else begin
            tb = timer2_bus;
        end
        // only judged on an increment, so a stale count never rematches
        pri_hit = tb.tick && (tb.count == state_reg.primary);
        sec_hit = tb.tick && (tb.count == state_reg.secondary);
        zero_hit = tb.tick && (tb.count == `OCP_COUNT_ZERO);
        period_hit = tb.tick && (tb.count == tb.period);
    end

    // apb read mux, sampled in the setup cycle
    always_comb begin
        rd_word = `OCP_WORD_RESET;
        rd_err = 1'b0;
        if (addr_is(paddr, `OCP_OFF_CTRL)) begin
            rd_word[`OCP_CTRL_MODE_MSB:`OCP_CTRL_MODE_LSB] = state_reg.mode;
            rd_word[`OCP_CTRL_TSEL_BIT] = state_reg.tsel;
            rd_word[`OCP_CTRL_FAULT_BIT] = state_reg.fault;
        end else if (addr_is(paddr, `OCP_OFF_PRI)) begin
            rd_word[15:0] = state_reg.primary;
        end else if (addr_is(paddr, `OCP_OFF_SEC)) begin
            rd_word[15:0] = state_reg.secondary;
        end else if (addr_is(paddr, `OCP_OFF_STAT)) begin
            rd_word[`OCP_STAT_FLAG_BIT] = state_reg.irq_flag;
            rd_word[`OCP_STAT_IEN_BIT] = state_reg.irq_en;
            rd_word[`OCP_STAT_PIN_BIT] = state_reg.pin;
        end else begin
            rd_err = 1'b1;
        end
    end

    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pwrite && ce;

    always_comb begin
        state_next = state_reg;
        if (apb_setup) begin
            state_next.rdata = rd_word;
            state_next.slverr = rd_err;
        end
        if (apb_write && addr_is(paddr, `OCP_OFF_PRI)) begin
            // active duty register is locked while pwm runs
            if (!mode_is_pwm(state_reg.mode)) begin
                state_next.primary = pwdata[15:0];
            end
        end
        if (apb_write && addr_is(paddr, `OCP_OFF_SEC)) begin
            state_next.secondary = pwdata[15:0];
        end
        if (apb_write && addr_is(paddr, `OCP_OFF_STAT)) begin
            state_next.irq_en = pwdata[`OCP_STAT_IEN_BIT];
            if (pwdata[`OCP_STAT_FLAG_BIT]) begin
                state_next.irq_flag = 1'b0;
            end
        end
        if (apb_write && addr_is(paddr, `OCP_OFF_CTRL)) begin
            state_next.mode = pwdata[`OCP_CTRL_MODE_MSB:`OCP_CTRL_MODE_LSB];
            state_next.tsel = pwdata[`OCP_CTRL_TSEL_BIT];
            // any control write restarts the output from low
            state_next.pin = 1'b0;
            state_next.fault = 1'b0;
            if (mode_is_pulse(pwdata[2:0])) begin
                // timer keeps running; no stop or clear needed
                state_next.pstate = ocp_pkg::ocp_st_rise;
            end else begin
                state_next.pstate = ocp_pkg::ocp_st_idle;
            end
        end else begin
            case (state_reg.mode)
                `OCP_MODE_SINGLE, `OCP_MODE_CONT: begin
                    case (state_reg.pstate)
                        ocp_pkg::ocp_st_rise: begin
                            if (pri_hit) begin
                                state_next.pin = 1'b1;
                                state_next.pstate = ocp_pkg::ocp_st_fall;
                            end
                        end
                        ocp_pkg::ocp_st_fall: begin
                            if (sec_hit) begin
                                state_next.pin = 1'b0;
                                state_next.irq_flag = 1'b1;
                                if (state_reg.mode == `OCP_MODE_SINGLE) begin
                                    state_next.pstate = ocp_pkg::ocp_st_done;
                                end else begin
                                    state_next.pstate = ocp_pkg::ocp_st_rise;
                                end
                            end
                        end
                        ocp_pkg::ocp_st_done: begin
                            state_next.pin = 1'b0;
                        end
                        default: begin
                            state_next.pin = 1'b0;
                        end
                    endcase
                end
                `OCP_MODE_PWM, `OCP_MODE_PWM_FAULT: begin
                    // period end latches the buffered duty for next cycle
                    if (period_hit) begin
                        state_next.primary = state_reg.secondary;
                    end
                    // cycle starts at zero after wrap: n plus one counts
                    if (zero_hit) begin
                        state_next.pin = (state_reg.primary != `OCP_CMP_RESET);
                    end
                    // duty above period never matches, pin stays high
                    if (pri_hit) begin
                        state_next.pin = 1'b0;
                    end
                    if (state_reg.mode == `OCP_MODE_PWM_FAULT) begin
                        if (!fault_n) begin
                            state_next.fault = 1'b1;
                            state_next.pin = 1'b0;
                            state_next.irq_flag = 1'b1;
                        end else if (state_reg.fault) begin
                            // hardware clear at next period start (a control write also clears)
                            state_next.pin = 1'b0;
                            if (zero_hit) begin
                                state_next.fault = 1'b0;
                                state_next.pin = (state_reg.primary != `OCP_CMP_RESET);
                            end
                        end
                    end
                end
                default: begin
                    state_next.pin = 1'b0;
                    state_next.pstate = ocp_pkg::ocp_st_idle;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg.pin <= 1'b0;
            state_reg.pstate <= ocp_pkg::ocp_st_idle;
            state_reg.mode <= `OCP_MODE_RESET;
            state_reg.tsel <= 1'b0;
            state_reg.fault <= 1'b0;
            state_reg.primary <= `OCP_CMP_RESET;
            state_reg.secondary <= `OCP_CMP_RESET;
            state_reg.irq_flag <= 1'b0;
            state_reg.irq_en <= 1'b0;
            state_reg.rdata <= `OCP_WORD_RESET;
            state_reg.slverr <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // access phase completes at once unless the block is frozen
    assign pready = ce;
    assign prdata = state_reg.rdata;
    assign pslverr = state_reg.slverr;
    assign compare_output_pin = state_reg.pin;
    assign compare_irq_flag = state_reg.irq_flag;
    assign compare_irq_request = state_reg.irq_flag && state_reg.irq_en;
    assign fault_status_flag = state_reg.fault;

endmodule

`default_nettype wire

// ==== ocp_timer_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ocp_timer_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic [15:0] per,
    output ocp_pkg::ocp_timer_t bus
);
    logic [15:0] cnt_reg;
    logic tick_reg;
    logic ph_reg;
    // ticks every other cycle so each fresh count stands two cycles
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= 16'h0000;
            tick_reg <= 1'b0;
            ph_reg <= 1'b0;
        end else begin
            ph_reg <= ~ph_reg;
            tick_reg <= run & ph_reg;
            if (run & ph_reg) begin
                cnt_reg <= (cnt_reg == per) ? 16'h0000 : cnt_reg + 16'h0001;
            end
        end
    end
    assign bus = '{count: cnt_reg, period: per, tick: tick_reg};
endmodule
`default_nettype wire

// ==== ocp_output_compare_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module ocp_output_compare_asserts (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire ocp_pkg::ocp_timer_t timer2_bus,
    input wire ocp_pkg::ocp_timer_t timer3_bus,
    input wire logic fault_n,
    input wire logic compare_output_pin,
    input wire logic compare_irq_flag,
    input wire logic compare_irq_request,
    input wire logic fault_status_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic tk;
    assign tk = timer2_bus.tick | timer3_bus.tick;
    chk_req_needs_flag: assert property (
        compare_irq_request |-> compare_irq_flag) else $error("request without flag");
    chk_flag_sticky: assert property (
        compare_irq_flag && !(psel && penable) |=> compare_irq_flag)
        else $error("flag dropped without write");
    chk_pin_on_event: assert property (
        $changed(compare_output_pin) |-> $past(tk || (psel && penable) || !fault_n))
        else $error("pin moved without event");
    chk_flag_on_match: assert property (
        $rose(compare_irq_flag) |-> $past(tk || !fault_n)) else $error("flag rose untimed");
    chk_fault_sets_irq: assert property (
        $rose(fault_status_flag) |-> compare_irq_flag && $past(!fault_n))
        else $error("fault flag without cause");
    chk_fault_pin_low: assert property (
        fault_status_flag |-> !compare_output_pin) else $error("pin high in fault");
    chk_fault_hw_clear: assert property (
        $fell(fault_status_flag) |-> $past(tk && fault_n)) else $error("fault flag cleared early");
    chk_unmapped_err: assert property (
        psel && penable && pready && paddr == 8'h10 |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    cov_pin_rise: cover property ($rose(compare_output_pin));
    cov_flag_rise: cover property ($rose(compare_irq_flag));
    cov_fault: cover property ($rose(fault_status_flag));
endmodule
bind ocp_output_compare ocp_output_compare_asserts i_chk (.clk, .nrst, .paddr, .psel,
    .penable, .prdata, .pready, .pslverr, .timer2_bus, .timer3_bus, .fault_n,
    .compare_output_pin, .compare_irq_flag, .compare_irq_request, .fault_status_flag);
`default_nettype wire

// ==== ocp_output_compare_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module ocp_output_compare_tb_top;
    logic clk = 0, nrst = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, fault_n = 1;
    logic run2 = 0, run3 = 0, pready, pslverr, pin, flag, req, flt;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [15:0] per2 = 16'h0014, per3 = 16'h000F;
    ocp_pkg::ocp_timer_t t2, t3;
    int bad_count = 0, checks_done = 0, hi, pw;
    always #5 clk = ~clk;
    ocp_timer_model i_ocp_timer_model (.clk(clk), .nrst(nrst), .run(run2), .per(per2), .bus(t2));
    ocp_timer_model i_ocp_timer_model_b (.clk(clk), .nrst(nrst), .run(run3), .per(per3), .bus(t3));
    ocp_output_compare i_ocp_output_compare (.clk(clk), .nrst(nrst), .ce(ce), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer2_bus(t2), .timer3_bus(t3),
        .fault_n(fault_n), .compare_output_pin(pin), .compare_irq_flag(flag),
        .compare_irq_request(req), .fault_status_flag(flt));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
        if (n >= 50) begin bad_count++; stop_test(); end
        rd = prdata;
        psel <= 0; penable <= 0;
        // let the access edge's register updates settle before callers look
        @(posedge clk);
    endtask
    // waits on negedge so the edge's own updates have landed
    task automatic wpin(input logic lv);
        int n;
        n = 0;
        do @(negedge clk); while (pin !== lv && ++n < 300);
        if (n >= 300) begin bad_count++; stop_test(); end
    endtask
    task automatic meas();
        wpin(0); wpin(1);
        hi = 0;
        while (pin === 1'b1 && hi < 300) begin @(negedge clk); hi++; end
        pw = hi;
        while (pin === 1'b0 && pw < 300) begin @(negedge clk); pw++; end
    endtask
    task automatic hold(input logic lv);
        int m;
        m = 0;
        repeat (44) begin @(negedge clk); m += (pin !== lv); end
        chk("held level", 0, m);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1;
        foreach (rd[i]) if (i < 4) begin apb(0, 8'(4 * i), 0); chk("reset reg", 0, rd); end
        apb(0, 8'h10, 0); chk("unmapped err", 1, pslverr);
        apb(1, 8'h04, 5); apb(1, 8'h08, 10); apb(1, 8'h0C, 2); apb(1, 8'h00, 4);
        chk("armed low", 0, pin); run2 <= 1;
        for (int k = 0; k < 2; k++) begin
            wpin(1); chk("rise count", 5, t2.count);
            wpin(0); chk("fall count", 10, t2.count);
            chk("irq request", 1, req); hold(0);
            apb(1, 8'h0C, 3); chk("flag cleared", 0, flag);
            apb(1, 8'h00, 4);
        end
        apb(1, 8'h04, 3); apb(1, 8'h08, 8); apb(1, 8'h00, 13); run3 <= 1;
        for (int k = 0; k < 2; k++) begin
            wpin(1); chk("cont rise", 3, t3.count);
            wpin(0); chk("cont fall", 8, t3.count); chk("cont flag", 1, flag);
            apb(1, 8'h0C, 3);
        end
        // buffer equals primary so an early period match cannot move the duty
        apb(1, 8'h04, 4); apb(1, 8'h08, 4); apb(1, 8'h00, 6);
        apb(0, 8'h04, 0); chk("first duty", 4, rd);
        apb(1, 8'h04, 7); apb(0, 8'h04, 0); chk("primary ro", 4, rd);
        apb(1, 8'h08, 9);
        meas(); meas(); chk("duty width", 18, hi); chk("period", 42, pw);
        apb(0, 8'h04, 0); chk("duty copied", 9, rd);
        apb(1, 8'h08, 20); meas(); meas(); chk("duty eq per", 40, hi);
        apb(1, 8'h08, 0); repeat (90) @(negedge clk); hold(0);
        apb(1, 8'h08, 30); repeat (90) @(negedge clk); hold(1);
        apb(1, 8'h08, 9); apb(1, 8'h00, 7); meas();
        @(posedge clk); fault_n <= 0; repeat (4) @(negedge clk);
        chk("fault flag", 1, flt); chk("fault pin", 0, pin); chk("fault irq", 1, flag);
        apb(0, 8'h00, 0); chk("ctrl fault bit", 32'h17, rd);
        @(posedge clk); fault_n <= 1;
        repeat (60) @(negedge clk); chk("fault cleared", 0, flt);
        @(posedge clk); ce <= 0; @(negedge clk); chk("stall ready", 0, pready);
        @(posedge clk); ce <= 1;
        stop_test();
    end
endmodule
`default_nettype wire
